// ---- ltpm_pkg.sv ----
package ltpm_pkg;
    localparam int          LOG_AW          = 16;
    localparam int          PHY_AW          = 20;
    localparam int          BASE_W          = 8;
    localparam int          PAGE_LSB        = 12;
    localparam logic [7:0]  UCB_OFFSET      = 8'h38;
    localparam logic [7:0]  BANK_OFFSET     = 8'h39;
    localparam logic [7:0]  AREA_OFFSET     = 8'h3a;
    localparam logic [7:0]  UCB_RESET       = 8'h00;
    localparam logic [7:0]  BANK_RESET      = 8'h00;
    localparam logic [7:0]  AREA_RESET      = 8'hf0;
    localparam int          UPPER_NIB_LSB   = 4;
    localparam int          BANK_NIB_LSB    = 0;
    localparam logic [7:0]  BASE_MASK_FULL  = 8'hff;
    localparam logic [7:0]  BASE_MASK_NARROW = 8'h7f;
    localparam logic [19:0] PHY_MASK_FULL   = 20'hf_ffff;
    localparam logic [19:0] PHY_MASK_HALF   = 20'h7_ffff;

    typedef enum logic [1:0] {
        LTPM_REG_LOWER,
        LTPM_REG_BANK,
        LTPM_REG_UPPER
    } ltpm_region_t;
endpackage

// ---- ltpm_cfg_regs.sv ----
`timescale 1ns/1ps
module ltpm_cfg_regs
    import ltpm_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       nrst_i,
    input  wire logic       wr_en_i,
    input  wire logic [7:0] wr_addr_i,
    input  wire logic [7:0] wr_data_i,
    input  wire logic [7:0] base_mask_i,
    output logic      [7:0] upper_common_base_o,
    output logic      [7:0] bank_base_o,
    output logic      [7:0] area_boundaries_o
);
    logic [7:0] ucb_reg;
    logic [7:0] ucb_next;
    logic [7:0] bank_reg;
    logic [7:0] bank_next;
    logic [7:0] area_reg;
    logic [7:0] area_next;

    always_comb begin
        ucb_next  = ucb_reg;
        bank_next = bank_reg;
        area_next = area_reg;
        if (wr_en_i) begin
            case (wr_addr_i)
                UCB_OFFSET:  ucb_next  = wr_data_i & base_mask_i;
                BANK_OFFSET: bank_next = wr_data_i & base_mask_i;
                AREA_OFFSET: area_next = wr_data_i;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ucb_reg  <= UCB_RESET;
            bank_reg <= BANK_RESET;
            area_reg <= AREA_RESET;
        end else begin
            ucb_reg  <= ucb_next;
            bank_reg <= bank_next;
            area_reg <= area_next;
        end
    end

    assign upper_common_base_o = ucb_reg;
    assign bank_base_o         = bank_reg;
    assign area_boundaries_o   = area_reg;
endmodule

// ---- ltpm_mapper.sv ----
`timescale 1ns/1ps
// Functional notes
// - Each 16-bit logical memory address becomes a 20-bit physical address.
// - Translation is combinational and adds no cycles to the access.
// - Logical space splits into lower common, bank and upper common regions.
// - Boundaries step in 4K, so only the top logical nibble selects a region.
// - Every memory access kind is translated, fetches, data, vectors and restarts.
// - I/O cycles pass the 16-bit address through with the top four bits zero.
// - When the transfer engine owns the bus its 20-bit address goes out, with bit 19 cleared in the half-space setting.
// - Comparators classify each memory access using the area boundaries register.
// - Physical address is region base plus top nibble, low 12 bits unchanged.
// - The upper common region uses the upper common base register.
// - The lower common region always maps with a zero base.
// - Area boundaries is read-write, upper nibble upper start, lower nibble bank start, reset f0.
// - Base registers are 8 bits in some variants and 7 bits in others.
// - The reduced-pin variant reaches only 512K, others the full 1M.
module ltpm_mapper
    import ltpm_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    input  wire logic        wide_base_i,
    input  wire logic        half_space_i,
    input  wire logic [15:0] log_addr_i,
    input  wire logic        mem_cycle_i,
    input  wire logic        io_cycle_i,
    input  wire logic        xfer_owns_bus_i,
    input  wire logic [19:0] xfer_addr_i,
    input  wire logic        io_wr_i,
    input  wire logic        io_rd_i,
    input  wire logic [7:0]  io_addr_i,
    input  wire logic [7:0]  io_wdata_i,
    output logic      [7:0]  io_rdata_o,
    output logic             io_hit_o,
    output logic      [19:0] phy_addr_o,
    output logic      [1:0]  region_o
);
    logic [7:0]   ucb;
    logic [7:0]   bank;
    logic [7:0]   area;
    logic [7:0]   base_mask;
    logic [19:0]  phy_mask;
    logic [3:0]   top_nib;
    ltpm_region_t region;
    logic [7:0]   sel_base;
    logic [19:0]  mapped;
    logic [19:0]  phy_raw;
    logic [7:0]   rdata_reg;
    logic [7:0]   rdata_next;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == UCB_OFFSET) || (a == BANK_OFFSET) || (a == AREA_OFFSET);
    endfunction

    // Strap levels are static; masks follow the package variant
    assign base_mask = wide_base_i ? BASE_MASK_FULL : BASE_MASK_NARROW;
    assign phy_mask  = half_space_i ? PHY_MASK_HALF : PHY_MASK_FULL;

    ltpm_cfg_regs u_regs (
        .mclk_i              (mclk_i),
        .nrst_i              (nrst_i),
        .wr_en_i             (io_wr_i),
        .wr_addr_i           (io_addr_i),
        .wr_data_i           (io_wdata_i),
        .base_mask_i         (base_mask),
        .upper_common_base_o (ucb),
        .bank_base_o         (bank),
        .area_boundaries_o   (area)
    );

    assign top_nib = log_addr_i[LOG_AW-1:PAGE_LSB];

    always_comb begin
        // Upper compare first so an inverted setting still resolves cleanly
        if (top_nib >= area[UPPER_NIB_LSB +: 4]) begin
            region   = LTPM_REG_UPPER;
            sel_base = ucb;
        end else if (top_nib >= area[BANK_NIB_LSB +: 4]) begin
            region   = LTPM_REG_BANK;
            sel_base = bank;
        end else begin
            region   = LTPM_REG_LOWER;
            sel_base = 8'h00;
        end
    end

    // Base aligns to 4K pages; the 8-bit sum fills bits 19:12
    assign mapped = {sel_base + {4'h0, top_nib}, log_addr_i[PAGE_LSB-1:0]};

    // Pure combinational path: no register between logical and physical address
    always_comb begin
        if (xfer_owns_bus_i) begin
            phy_raw = xfer_addr_i;
        end else if (io_cycle_i && !mem_cycle_i) begin
            phy_raw = {4'h0, log_addr_i};
        end else begin
            phy_raw = mapped;
        end
    end

    assign phy_addr_o = phy_raw & phy_mask;
    assign region_o   = region;
    assign io_hit_o   = (io_rd_i || io_wr_i) && is_mapped(io_addr_i);

    always_comb begin
        rdata_next = 8'h00;
        if (io_rd_i) begin
            case (io_addr_i)
                UCB_OFFSET:  rdata_next = ucb;
                BANK_OFFSET: rdata_next = bank;
                AREA_OFFSET: rdata_next = area;
                default:     rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign io_rdata_o = rdata_reg;
endmodule

// ---- ltpm_props.sv ----
`timescale 1ns/1ps
module ltpm_props
    import ltpm_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic half_space_i,
    input wire logic [15:0] log_addr_i,
    input wire logic mem_cycle_i,
    input wire logic io_cycle_i,
    input wire logic xfer_owns_bus_i,
    input wire logic [19:0] xfer_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_addr_i,
    input wire logic [7:0] io_rdata_o,
    input wire logic io_hit_o,
    input wire logic [19:0] phy_addr_o,
    input wire logic [1:0] region_o
);
    logic tr;
    assign tr = mem_cycle_i && !xfer_owns_bus_i;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    chk_xfer_direct: assert property (
        xfer_owns_bus_i |-> phy_addr_o == xfer_addr_i) else $error("xfer addr");
    chk_io_bypass: assert property (
        !xfer_owns_bus_i && io_cycle_i && !mem_cycle_i |-> phy_addr_o == {4'h0, log_addr_i})
        else $error("io addr");
    chk_low_bits: assert property (
        tr |-> phy_addr_o[11:0] == log_addr_i[11:0]) else $error("low bits");
    chk_lower_zero: assert property (
        tr && region_o == 2'd0 |-> phy_addr_o[19:12] == {4'h0, log_addr_i[15:12]})
        else $error("lower base");
    chk_half_space: assert property (
        half_space_i && !xfer_owns_bus_i |-> !phy_addr_o[19]) else $error("half space");
    chk_hit_map: assert property (
        io_hit_o == ((io_wr_i || io_rd_i) && io_addr_i inside {[8'h38:8'h3a]}))
        else $error("hit");
    chk_rdata_idle: assert property (
        !$past(io_rd_i) |-> io_rdata_o == 8'h00) else $error("rdata idle");
    chk_rdata_unmapped: assert property (
        $past(io_rd_i && !io_hit_o) |-> io_rdata_o == 8'h00) else $error("rdata unmapped");
endmodule
bind ltpm_mapper ltpm_props ltpm_props_inst (.*);

// ---- ltpm_core_model.sv ----
`timescale 1ns/1ps
module ltpm_core_model (
    input  wire logic        mclk_i,
    output logic      [15:0] log_addr_o,
    output logic             mem_o,
    output logic             io_o
);
    int seed = 32'h63061f7f;
    // New cycle each clock; both flags high is memory, neither is idle
    always @(negedge mclk_i) {log_addr_o, mem_o, io_o} <= 18'($random(seed));
endmodule

// ---- logical_to_physical_mapper_tb.sv ----
`timescale 1ns/1ps
module logical_to_physical_mapper_tb
    import ltpm_pkg::*;
;
    logic mclk_i = 1'b0;
    logic nrst_i, wide_base_i, half_space_i, mem_cycle_i, io_cycle_i, io_hit_o;
    logic xfer_owns_bus_i, io_wr_i, io_rd_i;
    logic [15:0] log_addr_i;
    logic [19:0] xfer_addr_i, phy_addr_o;
    logic [7:0] io_addr_i, io_wdata_i, io_rdata_o, a;
    logic [7:0] ucb = UCB_RESET, bnk = BANK_RESET, area = AREA_RESET;
    logic [1:0] region_o;
    logic [31:0] r;
    int seed = 32'h63061f7f;
    int miscompares = 0;
    int total_checks = 0;
    always #5 mclk_i = ~mclk_i;
    ltpm_mapper ltpm_mapper_inst (.*);
    ltpm_core_model ltpm_core_model_inst (.mclk_i, .log_addr_o(log_addr_i),
        .mem_o(mem_cycle_i), .io_o(io_cycle_i));
    function automatic logic [7:0] shadow(input logic [7:0] x);
        return x == UCB_OFFSET ? ucb : x == BANK_OFFSET ? bnk : x == AREA_OFFSET ? area : 8'h00;
    endfunction
    function automatic logic [19:0] ephy();
        logic [3:0] n;
        logic [7:0] b;
        n = log_addr_i[15:12];
        b = n >= area[7:4] ? ucb : n >= area[3:0] ? bnk : 8'h00;
        if (xfer_owns_bus_i) return xfer_addr_i;
        if (io_cycle_i && !mem_cycle_i) return {4'h0, log_addr_i};
        return {b + {4'h0, n}, log_addr_i[11:0]} & (half_space_i ? PHY_MASK_HALF : PHY_MASK_FULL);
    endfunction
    function automatic logic [1:0] eregion();
        logic [3:0] n;
        n = log_addr_i[15:12];
        return n >= area[7:4] ? 2'd2 : n >= area[3:0] ? 2'd1 : 2'd0;
    endfunction
    task automatic chk(input string s, input logic [19:0] e, input logic [19:0] g);
        total_checks++;
        if (e !== g) begin
            miscompares++;
            $display("unexpected %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] x, input logic [7:0] d);
        {io_wr_i, io_addr_i, io_wdata_i} = {1'b1, x, d};
        @(negedge mclk_i) io_wr_i = 1'b0;
        if (x == UCB_OFFSET) ucb = d & (wide_base_i ? BASE_MASK_FULL : BASE_MASK_NARROW);
        if (x == BANK_OFFSET) bnk = d & (wide_base_i ? BASE_MASK_FULL : BASE_MASK_NARROW);
        if (x == AREA_OFFSET) area = d;
    endtask
    task automatic rd(input logic [7:0] x);
        {io_rd_i, io_addr_i} = {1'b1, x};
        #1;
        chk("hit", {19'h0, x inside {UCB_OFFSET, BANK_OFFSET, AREA_OFFSET}}, {19'h0, io_hit_o});
        @(negedge mclk_i) io_rd_i = 1'b0;
        chk("rdata", {12'h000, shadow(x)}, {12'h000, io_rdata_o});
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        {nrst_i, wide_base_i, half_space_i, xfer_owns_bus_i, io_wr_i, io_rd_i} = '0;
        {xfer_addr_i, io_addr_i, io_wdata_i} = '0;
        repeat (4) @(posedge mclk_i);
        @(negedge mclk_i) nrst_i = 1'b1;
        for (int i = 0; i < 4; i++) rd(8'h38 + 8'(i));
        for (int i = 0; i < 3000; i++) begin
            chk("phy", ephy(), phy_addr_o);
            chk("region", {18'h0, eregion()}, {18'h0, region_o});
            r = $random(seed);
            {xfer_owns_bus_i, half_space_i, wide_base_i} = {r[3:0] == 4'h0, r[4], r[5]};
            xfer_addr_i = r[31:12] & (r[4] ? PHY_MASK_HALF : PHY_MASK_FULL);
            a = 8'h38 + {6'h00, r[10:9]};
            if (r[8:6] == 3'h0) begin
                wr(a, r[18:11]);
                rd(a);
            end
            else @(negedge mclk_i);
        end
        final_report();
    end
    initial begin
        #200_000;
        miscompares++;
        final_report();
    end
endmodule
